// *** rtl/pwb_consts.svh ***
// Offsets, field positions, widths and reset values of the waveform output block.
`ifndef PWB_CONSTS_SVH
`define PWB_CONSTS_SVH

`define PWB_CNT_W 16
`define PWB_CH_NUM 4
`define PWB_ADDR_W 8
`define PWB_DATA_W 32
`define PWB_OUTPUT_PATTERN_W 8
`define PWB_CNT_MAX 16'hFFFF

`define PWB_OFF_CTRLA 8'h00
`define PWB_OFF_CONTROL_B_CLR 8'h04
`define PWB_OFF_CONTROL_B_SET 8'h08
`define PWB_OFF_WAVE 8'h0C
`define PWB_OFF_STATUS 8'h10
`define PWB_OFF_SYNC_BUSY_FLAGS 8'h14
`define PWB_OFF_INTFLAG 8'h18
`define PWB_OFF_INTEN 8'h1C
`define PWB_OFF_COUNT 8'h20
`define PWB_OFF_OUTPUT_PATTERN 8'h24
`define PWB_OFF_OUTPUT_PATTERN_BUFFER 8'h28
`define PWB_OFF_PER 8'h2C
`define PWB_OFF_PERIOD_BUFFER 8'h30
`define PWB_OFF_CC0 8'h34
`define PWB_OFF_CCBUF0 8'h44

`define PWB_CTRLA_EN_BIT 0
`define PWB_CTRLA_MODE_LSB 1
`define PWB_CONTROL_B_DIR_BIT 0
`define PWB_CONTROL_B_LOCK_UPDATE_BIT 1

`define PWB_ST_OUTPUT_PATTERN_BIT 0
`define PWB_ST_PER_BIT 1
`define PWB_ST_CC_LSB 2
`define PWB_ST_W 6

`define PWB_INT_OVF_BIT 0
`define PWB_INT_ERR_BIT 1
`define PWB_INT_MC_LSB 2
`define PWB_INT_W 6

`define PWB_RST_PER 16'hFFFF
`define PWB_RST_CC 16'h0000
`define PWB_RST_OUTPUT_PATTERN 8'h00

`endif

// *** rtl/pwb_pkg.sv ***
// Types shared by the waveform output block.
package pwb_pkg;

   typedef enum logic [1:0]
   {
      PWB_NFRQ = 2'b00,
      PWB_MFRQ = 2'b01,
      PWB_NPWM = 2'b10,
      PWB_DSBOTH = 2'b11
   } pwb_mode_t;

   typedef struct packed
   {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } pwb_bus_req_t;

endpackage

// *** rtl/pwb_wave_top.sv ***
// Timer waveform generator with polarity control and double-buffered period, pattern and compare registers.
`timescale 1ns/10ps
`include "pwb_consts.svh"

module pwb_wave_top
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input pwb_pkg::pwb_bus_req_t bus_req,
   output logic [31:0] bus_rdata,
   output logic [`PWB_CH_NUM-1:0] wave_pin,
   output logic access_error,
   output logic irq
);

   logic enable_r;
   pwb_pkg::pwb_mode_t mode_r;
   logic dir_r;
   logic lock_update_r;
   logic [`PWB_CH_NUM-1:0] channel_output_polarity_r;
   logic [`PWB_CNT_W-1:0] count_r;
   logic [`PWB_OUTPUT_PATTERN_W-1:0] output_pattern_r;
   logic [`PWB_OUTPUT_PATTERN_W-1:0] output_pattern_buffer_r;
   logic [`PWB_CNT_W-1:0] period_value_r;
   logic [`PWB_CNT_W-1:0] period_buffer_r;
   logic [`PWB_CH_NUM-1:0][`PWB_CNT_W-1:0] compare_value_r;
   logic [`PWB_CH_NUM-1:0][`PWB_CNT_W-1:0] compare_buffer_r;
   logic pattern_buffer_valid_r;
   logic period_buffer_valid_r;
   logic [`PWB_CH_NUM-1:0] compare_buffer_valid_r;
   logic [`PWB_INT_W-1:0] intflag_r;
   logic [`PWB_INT_W-1:0] inten_r;
   logic [`PWB_CH_NUM-1:0] wave_r;
   logic [`PWB_CH_NUM-1:0] wave_nxt;
   logic [31:0] rdata_nxt;
   logic [`PWB_ST_W-1:0] status_bits;
   logic [`PWB_ST_W-1:0] sync_busy_flags;
   logic [`PWB_CNT_W-1:0] top_value;
   logic at_top;
   logic at_zero;
   logic update_event;
   logic copy_ok;
   logic wr_output_pattern;
   logic wr_output_pattern_buffer;
   logic wr_per;
   logic wr_period_buffer;
   logic [`PWB_CH_NUM-1:0] wr_cc;
   logic [`PWB_CH_NUM-1:0] wr_ccbuf;
   logic [`PWB_CH_NUM-1:0] cc_match;
   logic write_rejected;
   logic pwm_mode;

   // Word address of a per-channel register.
   function automatic logic [7:0] pwb_ch_addr(input logic [7:0] base, input int ch);
      pwb_ch_addr = base + 8'((ch * 4) & 8'hFF);
   endfunction

   // Next waveform level of one channel in the two PWM modes.
   function automatic logic pwb_pwm_next(input pwb_pkg::pwb_mode_t mode, input logic dir, input logic pol,
                                         input logic cur, input logic match, input logic top, input logic zero);
      logic set_c;
      logic clr_c;
      set_c = 1'b0;
      clr_c = 1'b0;
      if (mode == pwb_pkg::PWB_DSBOTH)
      begin
         set_c = match && (dir == pol);
         clr_c = match && (dir != pol);
      end
      else if (!dir)
      begin
         set_c = pol ? match : top;
         clr_c = pol ? top : match;
      end
      else
      begin
         set_c = pol ? zero : match;
         clr_c = pol ? match : zero;
      end
      // A set and a clear in the same cycle only happen when the compare value equals TOP or ZERO; set wins.
      if (set_c)
      begin
         pwb_pwm_next = 1'b1;
      end
      else if (clr_c)
      begin
         pwb_pwm_next = 1'b0;
      end
      else
      begin
         pwb_pwm_next = cur;
      end
   endfunction

   assign pwm_mode = (mode_r == pwb_pkg::PWB_NPWM) || (mode_r == pwb_pkg::PWB_DSBOTH);
   assign top_value = (mode_r == pwb_pkg::PWB_MFRQ) ? compare_value_r[0] :
                      (mode_r == pwb_pkg::PWB_NFRQ) ? `PWB_CNT_MAX : period_value_r;
   assign at_top = (count_r == top_value);
   assign at_zero = (count_r == '0);
   assign update_event = enable_r && ((!dir_r && at_top) || (dir_r && at_zero));
   assign copy_ok = update_event && !lock_update_r;

   assign status_bits = {compare_buffer_valid_r, period_buffer_valid_r, pattern_buffer_valid_r};
   assign sync_busy_flags = status_bits;

   assign wr_output_pattern = bus_req.wr && (bus_req.addr == `PWB_OFF_OUTPUT_PATTERN);
   assign wr_output_pattern_buffer = bus_req.wr && (bus_req.addr == `PWB_OFF_OUTPUT_PATTERN_BUFFER);
   assign wr_per = bus_req.wr && (bus_req.addr == `PWB_OFF_PER);
   assign wr_period_buffer = bus_req.wr && (bus_req.addr == `PWB_OFF_PERIOD_BUFFER);

   always_comb
   begin
      write_rejected = ((wr_output_pattern || wr_output_pattern_buffer) && pattern_buffer_valid_r) ||
                       ((wr_per || wr_period_buffer) && period_buffer_valid_r);
      for (int i = 0; i < `PWB_CH_NUM; i++)
      begin
         wr_cc[i] = bus_req.wr && (bus_req.addr == pwb_ch_addr(`PWB_OFF_CC0, i));
         wr_ccbuf[i] = bus_req.wr && (bus_req.addr == pwb_ch_addr(`PWB_OFF_CCBUF0, i));
         cc_match[i] = enable_r && (count_r == compare_value_r[i]);
         if ((wr_cc[i] || wr_ccbuf[i]) && compare_buffer_valid_r[i])
         begin
            write_rejected = 1'b1;
         end
      end
   end

   // Control, direction and lock bits.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         enable_r <= 1'b0;
         mode_r <= pwb_pkg::PWB_NFRQ;
         dir_r <= 1'b0;
         lock_update_r <= 1'b0;
         channel_output_polarity_r <= '0;
         inten_r <= '0;
      end
      else
      begin
         if (bus_req.wr && bus_req.addr == `PWB_OFF_CTRLA)
         begin
            enable_r <= bus_req.wdata[`PWB_CTRLA_EN_BIT];
            mode_r <= pwb_pkg::pwb_mode_t'(bus_req.wdata[`PWB_CTRLA_MODE_LSB +: 2]);
         end
         if (bus_req.wr && bus_req.addr == `PWB_OFF_WAVE)
         begin
            channel_output_polarity_r <= bus_req.wdata[`PWB_CH_NUM-1:0];
         end
         if (bus_req.wr && bus_req.addr == `PWB_OFF_INTEN)
         begin
            inten_r <= bus_req.wdata[`PWB_INT_W-1:0];
         end
         // Dual-slope turns around at TOP and ZERO; software writes below take precedence.
         if (enable_r && mode_r == pwb_pkg::PWB_DSBOTH)
         begin
            if (!dir_r && at_top)
            begin
               dir_r <= 1'b1;
            end
            else if (dir_r && at_zero)
            begin
               dir_r <= 1'b0;
            end
         end
         if (bus_req.wr && bus_req.addr == `PWB_OFF_CONTROL_B_CLR)
         begin
            if (bus_req.wdata[`PWB_CONTROL_B_DIR_BIT])
            begin
               dir_r <= 1'b0;
            end
            if (bus_req.wdata[`PWB_CONTROL_B_LOCK_UPDATE_BIT])
            begin
               lock_update_r <= 1'b0;
            end
         end
         if (bus_req.wr && bus_req.addr == `PWB_OFF_CONTROL_B_SET)
         begin
            if (bus_req.wdata[`PWB_CONTROL_B_DIR_BIT])
            begin
               dir_r <= 1'b1;
            end
            if (bus_req.wdata[`PWB_CONTROL_B_LOCK_UPDATE_BIT])
            begin
               lock_update_r <= 1'b1;
            end
         end
      end
   end

   // Counter: up counts from ZERO to TOP, down from TOP to ZERO, dual-slope reflects at both ends.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         count_r <= '0;
      end
      else if (bus_req.wr && bus_req.addr == `PWB_OFF_COUNT)
      begin
         count_r <= bus_req.wdata[`PWB_CNT_W-1:0];
      end
      else if (enable_r)
      begin
         if (!dir_r)
         begin
            if (!at_top)
            begin
               count_r <= count_r + 16'h0001;
            end
            else
            begin
               count_r <= (mode_r == pwb_pkg::PWB_DSBOTH) ? count_r - 16'h0001 : '0;
            end
         end
         else
         begin
            if (!at_zero)
            begin
               count_r <= count_r - 16'h0001;
            end
            else
            begin
               count_r <= (mode_r == pwb_pkg::PWB_DSBOTH) ? 16'h0001 : top_value;
            end
         end
      end
   end

   // Pattern register and its buffer.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         output_pattern_r <= `PWB_RST_OUTPUT_PATTERN;
         output_pattern_buffer_r <= `PWB_RST_OUTPUT_PATTERN;
         pattern_buffer_valid_r <= 1'b0;
      end
      else if (!pattern_buffer_valid_r)
      begin
         if (wr_output_pattern)
         begin
            output_pattern_r <= bus_req.wdata[`PWB_OUTPUT_PATTERN_W-1:0];
         end
         if (wr_output_pattern_buffer)
         begin
            output_pattern_buffer_r <= bus_req.wdata[`PWB_OUTPUT_PATTERN_W-1:0];
            pattern_buffer_valid_r <= 1'b1;
         end
      end
      else if (copy_ok)
      begin
         output_pattern_r <= output_pattern_buffer_r;
         pattern_buffer_valid_r <= 1'b0;
      end
   end // Locked updates fall through and keep the buffer pending.

   // Period register and its buffer.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         period_value_r <= `PWB_RST_PER;
         period_buffer_r <= `PWB_RST_PER;
         period_buffer_valid_r <= 1'b0;
      end
      else if (!period_buffer_valid_r)
      begin
         if (wr_per)
         begin
            period_value_r <= bus_req.wdata[`PWB_CNT_W-1:0];
         end
         if (wr_period_buffer)
         begin
            period_buffer_r <= bus_req.wdata[`PWB_CNT_W-1:0];
            period_buffer_valid_r <= 1'b1;
         end
      end
      else if (copy_ok)
      begin
         period_value_r <= period_buffer_r;
         period_buffer_valid_r <= 1'b0;
      end
   end

   // Compare registers and their buffers.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         compare_value_r <= '0;
         compare_buffer_r <= '0;
         compare_buffer_valid_r <= '0;
      end
      else
      begin
         for (int i = 0; i < `PWB_CH_NUM; i++)
         begin
            if (!compare_buffer_valid_r[i])
            begin
               if (wr_cc[i])
               begin
                  compare_value_r[i] <= bus_req.wdata[`PWB_CNT_W-1:0];
               end
               if (wr_ccbuf[i])
               begin
                  compare_buffer_r[i] <= bus_req.wdata[`PWB_CNT_W-1:0];
                  compare_buffer_valid_r[i] <= 1'b1;
               end
            end
            else if (copy_ok)
            begin
               compare_value_r[i] <= compare_buffer_r[i];
               compare_buffer_valid_r[i] <= 1'b0;
            end
         end
      end
   end

   // Waveform levels. The frequency modes keep the output at polarity until the first toggle.
   always_comb
   begin
      wave_nxt = wave_r;
      for (int i = 0; i < `PWB_CH_NUM; i++)
      begin
         if (!enable_r)
         begin
            wave_nxt[i] = channel_output_polarity_r[i];
         end
         else if (pwm_mode)
         begin
            wave_nxt[i] = pwb_pwm_next(mode_r, dir_r, channel_output_polarity_r[i], wave_r[i],
                                       cc_match[i], at_top, at_zero);
         end
         else if (cc_match[i])
         begin
            wave_nxt[i] = ~wave_r[i];
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         wave_r <= '0;
         wave_pin <= '0;
      end
      else
      begin
         wave_r <= wave_nxt;
         for (int i = 0; i < `PWB_CH_NUM; i++)
         begin
            wave_pin[i] <= output_pattern_r[i] ? output_pattern_r[i + `PWB_CH_NUM] : wave_nxt[i];
         end
      end
   end

   // Sticky interrupt flags; a new event wins over a write-one-to-clear in the same cycle.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         intflag_r <= '0;
         access_error <= 1'b0;
      end
      else
      begin
         access_error <= write_rejected;
         intflag_r <= (intflag_r & ~((bus_req.wr && bus_req.addr == `PWB_OFF_INTFLAG) ?
                       bus_req.wdata[`PWB_INT_W-1:0] : '0)) |
                      {cc_match, write_rejected, update_event};
      end
   end

   assign irq = |(intflag_r & inten_r);

   // Read data, valid in the cycle after the strobe. Active registers read back as stored even while
   // their buffer is valid; software must not rely on them then.
   always_comb
   begin
      rdata_nxt = '0;
      unique case (bus_req.addr)
         `PWB_OFF_CTRLA: rdata_nxt = {29'h0, mode_r, enable_r};
         `PWB_OFF_CONTROL_B_CLR, `PWB_OFF_CONTROL_B_SET: rdata_nxt = {30'h0, lock_update_r, dir_r};
         `PWB_OFF_WAVE: rdata_nxt = {28'h0, channel_output_polarity_r};
         `PWB_OFF_STATUS: rdata_nxt = {26'h0, status_bits};
         `PWB_OFF_SYNC_BUSY_FLAGS: rdata_nxt = {26'h0, sync_busy_flags};
         `PWB_OFF_INTFLAG: rdata_nxt = {26'h0, intflag_r};
         `PWB_OFF_INTEN: rdata_nxt = {26'h0, inten_r};
         `PWB_OFF_COUNT: rdata_nxt = {16'h0, count_r};
         `PWB_OFF_OUTPUT_PATTERN: rdata_nxt = {24'h0, output_pattern_r};
         `PWB_OFF_OUTPUT_PATTERN_BUFFER: rdata_nxt = {24'h0, output_pattern_buffer_r};
         `PWB_OFF_PER: rdata_nxt = {16'h0, period_value_r};
         `PWB_OFF_PERIOD_BUFFER: rdata_nxt = {16'h0, period_buffer_r};
         default:
         begin
            for (int i = 0; i < `PWB_CH_NUM; i++)
            begin
               if (bus_req.addr == pwb_ch_addr(`PWB_OFF_CC0, i))
               begin
                  rdata_nxt = {16'h0, compare_value_r[i]};
               end
               if (bus_req.addr == pwb_ch_addr(`PWB_OFF_CCBUF0, i))
               begin
                  rdata_nxt = {16'h0, compare_buffer_r[i]};
               end
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         bus_rdata <= '0;
      end
      else if (bus_req.rd)
      begin
         bus_rdata <= rdata_nxt;
      end
      else
      begin
         bus_rdata <= '0;
      end
   end

endmodule

// *** verification/pwb_wave_load.sv ***
// Load model on the waveform pins: counts the cycles each channel spends high inside a window.
`timescale 1ns/10ps
`include "pwb_consts.svh"
module pwb_wave_load
(
   input wire logic sys_clk,
   input wire logic clr,
   input wire logic meas,
   input wire logic [`PWB_CH_NUM-1:0] pins,
   output logic [`PWB_CH_NUM-1:0][15:0] high_cnt
);
   // The load only listens, so duty is judged over whole periods and not edge by edge.
   always_ff @(posedge sys_clk)
   begin
      for (int i = 0; i < `PWB_CH_NUM; i++)
      begin
         if (clr)
         begin
            high_cnt[i] <= 16'h0000;
         end
         else if (meas && pins[i])
         begin
            high_cnt[i] <= high_cnt[i] + 16'h0001;
         end
      end
   end
endmodule

// *** verification/pwb_wave_top_asserts.sv ***
// Concurrent checks on the ports of the waveform output block.
`timescale 1ns/10ps
`include "pwb_consts.svh"
module pwb_wave_chk
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire pwb_pkg::pwb_bus_req_t bus_req,
   input wire logic [31:0] bus_rdata,
   input wire logic [`PWB_CH_NUM-1:0] wave_pin,
   input wire logic access_error,
   input wire logic irq
);
   logic [5:0] inten_r;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // Shadow of the mask, so the interrupt line is judged without looking inside.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         inten_r <= 6'h00;
      end
      else if (bus_req.wr && bus_req.addr == `PWB_OFF_INTEN)
      begin
         inten_r <= bus_req.wdata[5:0];
      end
   end
   a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
      else $error("read data seen without a read");
   a_unmapped_zero: assert property ($past(bus_req.rd) && $past(bus_req.addr) > 8'h50 |-> bus_rdata == 32'h0)
      else $error("unmapped read returned data");
   a_status_width: assert property ($past(bus_req.rd) && ($past(bus_req.addr) == `PWB_OFF_STATUS ||
      $past(bus_req.addr) == `PWB_OFF_SYNC_BUSY_FLAGS) |-> bus_rdata[31:6] == 26'h0)
      else $error("status read has stray upper bits");
   a_err_after_write: assert property (access_error |-> $past(bus_req.wr))
      else $error("access error without a write");
   a_err_raises_irq: assert property (access_error && inten_r[1] |-> irq)
      else $error("enabled access error did not raise the interrupt");
   a_irq_masked: assert property (irq |-> inten_r != 6'h00)
      else $error("interrupt high while every source is masked");
   a_dir_clear_up: assert property (bus_req.wr && bus_req.addr == `PWB_OFF_CONTROL_B_CLR && bus_req.wdata[0]
      ##[1:2] bus_req.rd && bus_req.addr == `PWB_OFF_CONTROL_B_CLR |=> bus_rdata[0] == 1'b0)
      else $error("direction not cleared to counting up");
   a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=>
      bus_rdata == 32'h0 && !access_error && !irq && wave_pin == '0)
      else $error("outputs not quiet after reset");
endmodule
bind pwb_wave_top pwb_wave_chk u_chk
(
   .sys_clk(sys_clk),
   .rst_n(rst_n),
   .bus_req(bus_req),
   .bus_rdata(bus_rdata),
   .wave_pin(wave_pin),
   .access_error(access_error),
   .irq(irq)
);

// *** verification/pwb_wave_top_tb.sv ***
// Self-checking bench for the waveform output block.
`timescale 1ns/10ps
`include "pwb_consts.svh"
module pwb_wave_top_tb;
   typedef struct packed
   {
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [7:0] raddr;
      logic [31:0] exp;
   } pwb_row_t;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   pwb_pkg::pwb_bus_req_t bus_req = '0;
   logic [31:0] bus_rdata;
   logic [3:0] wave_pin;
   logic access_error;
   logic irq;
   logic clr = 1'b0;
   logic meas = 1'b0;
   logic [3:0][15:0] high_cnt;
   logic [31:0] rd_val;
   int errors = 0;
   int checked = 0;
   pwb_row_t rows [9] = '{'{8'h08, 32'h1, 8'h08, 32'h1}, '{8'h04, 32'h0, 8'h04, 32'h1},
      '{8'h04, 32'h1, 8'h04, 32'h0}, '{8'h0C, 32'hA, 8'h0C, 32'hA}, '{8'h2C, 32'h10, 8'h2C, 32'h10},
      '{8'h34, 32'h4, 8'h34, 32'h4}, '{8'h38, 32'h4, 8'h38, 32'h4}, '{8'h1C, 32'h2, 8'h1C, 32'h2},
      '{8'hFC, 32'hFFFFFFFF, 8'hFC, 32'h0}};
   logic [7:0] bufs [3] = '{8'h28, 8'h30, 8'h44};
   logic [7:0] acts [3] = '{8'h24, 8'h2C, 8'h34};
   logic [31:0] bvals [3] = '{32'h0, 32'h20, 32'h6};
   logic [7:0] raddr [6] = '{8'h2C, 8'h30, 8'h34, 8'h24, 8'h10, 8'h04};
   logic [31:0] rexp [6] = '{32'hFFFF, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'h0};

   always #5 sys_clk = ~sys_clk;

   pwb_wave_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .wave_pin(wave_pin), .access_error(access_error), .irq(irq));
   pwb_wave_load load (.sys_clk(sys_clk), .clr(clr), .meas(meas), .pins(wave_pin), .high_cnt(high_cnt));

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("Error t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      bus_req.addr <= a;
      bus_req.wdata <= d;
      bus_req.wr <= 1'b1;
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a);
      @(posedge sys_clk);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1;
      rd_val = bus_rdata;
   endtask

   // Windows are whole periods long, so the start phase does not change the totals.
   task automatic check_high(input int n, input logic [63:0] e);
      @(posedge sys_clk);
      clr <= 1'b1;
      @(posedge sys_clk);
      clr <= 1'b0;
      meas <= 1'b1;
      repeat (n) @(posedge sys_clk);
      meas <= 1'b0;
      #1;
      for (int i = 0; i < 4; i++)
      begin
         cmp({16'h0000, high_cnt[i]}, {16'h0000, e[i*16 +: 16]});
      end
   endtask

   task automatic report_and_stop;
      $display("Checks %0d, errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
      begin
         $display("== PASSED ==");
      end
      else
      begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial
   begin
      #900000;
      errors++;
      report_and_stop;
   end

   initial
   begin
      int n;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      foreach (rows[i])
      begin
         bus_wr(rows[i].waddr, rows[i].wdata);
         bus_rd(rows[i].raddr);
         cmp(rd_val, rows[i].exp);
      end
      cmp({28'h0, wave_pin}, 32'hA);
      bus_wr(`PWB_OFF_CTRLA, 32'h5);
      repeat (20) @(posedge sys_clk);
      check_high(68, 64'h0040_0004_0030_0014);
      bus_wr(`PWB_OFF_CONTROL_B_SET, 32'h1);
      repeat (20) @(posedge sys_clk);
      check_high(68, 64'h0044_0044_0034_0010);
      bus_wr(8'h3C, 32'h8);
      bus_wr(8'h40, 32'h8);
      bus_wr(`PWB_OFF_CTRLA, 32'h7);
      repeat (40) @(posedge sys_clk);
      check_high(128, 64'h0040_0040_0020_0060);
      bus_wr(`PWB_OFF_CONTROL_B_SET, 32'h2);
      for (int i = 0; i < 3; i++)
      begin
         bus_wr(bufs[i], bvals[i]);
         bus_rd(`PWB_OFF_SYNC_BUSY_FLAGS);
         cmp(rd_val, (32'h1 << (i + 1)) - 32'h1);
         bus_wr(acts[i], 32'h3);
         #1;
         cmp({31'h0, access_error}, 32'h1);
         bus_wr(bufs[i], 32'h5);
         #1;
         cmp({31'h0, access_error}, 32'h1);
      end
      cmp({31'h0, irq}, 32'h1);
      bus_wr(`PWB_OFF_INTEN, 32'h0);
      #1;
      cmp({31'h0, irq}, 32'h0);
      bus_wr(`PWB_OFF_INTEN, 32'h2);
      #1;
      cmp({31'h0, irq}, 32'h1);
      // The active period must not be read back while its buffer is valid, so the lock is judged by the duty.
      check_high(128, 64'h0040_0040_0020_0060);
      bus_rd(`PWB_OFF_PERIOD_BUFFER);
      cmp(rd_val, 32'h20);
      bus_rd(`PWB_OFF_STATUS);
      cmp(rd_val, 32'h7);
      bus_wr(`PWB_OFF_CONTROL_B_CLR, 32'h2);
      for (n = 0; n < 50; n++)
      begin
         bus_rd(`PWB_OFF_STATUS);
         if (rd_val === 32'h0)
         begin
            break;
         end
      end
      if (n == 50)
      begin
         errors++;
         report_and_stop;
      end
      bus_rd(`PWB_OFF_PER);
      cmp(rd_val, 32'h20);
      bus_rd(`PWB_OFF_CC0);
      cmp(rd_val, 32'h6);
      bus_rd(`PWB_OFF_SYNC_BUSY_FLAGS);
      cmp(rd_val, 32'h0);
      bus_wr(`PWB_OFF_INTFLAG, 32'h2);
      #1;
      cmp({31'h0, irq}, 32'h0);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      cmp({28'h0, wave_pin}, 32'h0);
      for (int i = 0; i < 6; i++)
      begin
         bus_rd(raddr[i]);
         cmp(rd_val, rexp[i]);
      end
      // Match frequency: TOP is the first compare value and each channel toggles from its polarity.
      bus_wr(`PWB_OFF_WAVE, 32'h5);
      bus_wr(`PWB_OFF_CC0, 32'h7);
      bus_wr(8'h38, 32'h3);
      bus_wr(`PWB_OFF_CTRLA, 32'h3);
      #1;
      cmp({28'h0, wave_pin}, 32'h5);
      @(posedge sys_clk);
      #1;
      cmp({28'h0, wave_pin}, 32'h9);
      check_high(64, 64'h0020_0020_0020_0020);
      report_and_stop;
   end
endmodule
